//--- rtl/ebpt_pkg.sv
package ebpt_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int         EBPT_MAX_TIMERS  = 5;
    localparam logic [7:0] EBPT_ADDR_FLAGS  = 8'h00;
    localparam logic [7:0] EBPT_ADDR_ENABLE = 8'h04;
    localparam logic [7:0] EBPT_ADDR_PRIO   = 8'h08;
    localparam logic [7:0] EBPT_ADDR_DIS    = 8'h0C;
    localparam logic [7:0] EBPT_ADDR_TBASE  = 8'h10;
    localparam logic [3:0] EBPT_OFS_COUNT   = 4'h0;
    localparam logic [3:0] EBPT_OFS_CONTROL = 4'h4;
    localparam logic [3:0] EBPT_OFS_PERIOD  = 4'h8;

    // ------------------------------------------------------------
    // Reset values and control field layout
    // ------------------------------------------------------------
    localparam logic [7:0] EBPT_PERIOD_RST  = 8'hFF;
    localparam logic [7:0] EBPT_COUNT_RST   = 8'h00;
    localparam logic [7:0] EBPT_CONTROL_RST = 8'h00;
    localparam logic [7:0] EBPT_CTRL_MASK   = 8'h7F;
    localparam int         EBPT_CTRL_PS_LSB = 0;
    localparam int         EBPT_CTRL_ON     = 2;
    localparam int         EBPT_CTRL_PO_LSB = 3;

    // Prescaler terminal counts for 1, 4 and 16
    localparam logic [3:0] EBPT_PRE_LIM_1   = 4'h0;
    localparam logic [3:0] EBPT_PRE_LIM_4   = 4'h3;
    localparam logic [3:0] EBPT_PRE_LIM_16  = 4'hF;

    // Flag/enable/priority bit of each timer, index 4 first
    localparam logic [4:0][2:0] EBPT_FLAG_POS = {3'h6, 3'h5, 3'h4, 3'h2, 3'h0};

    // ------------------------------------------------------------
    // Bus answers and decoded register kinds
    // ------------------------------------------------------------
    localparam logic [1:0] EBPT_RESP_OKAY   = 2'h0;
    localparam logic [1:0] EBPT_RESP_SLVERR = 2'h2;

    typedef enum logic [7:0] {
        EBPT_K_NONE    = 8'h00,
        EBPT_K_FLAGS   = 8'h01,
        EBPT_K_ENABLE  = 8'h02,
        EBPT_K_PRIO    = 8'h04,
        EBPT_K_DIS     = 8'h08,
        EBPT_K_COUNT   = 8'h10,
        EBPT_K_CONTROL = 8'h20,
        EBPT_K_PERIOD  = 8'h40
    } ebpt_kind_t;

endpackage : ebpt_pkg

//--- rtl/ebpt_timer_top.sv
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
// Function
// - Counter counts up from zero and wraps to zero after matching the period.
// - Every period register reloads all ones on reset.
// - Each timer has an eight-bit period register, read and write at any time unless its disable bit holds it at reset.
// - Unscaled match pulses also go to the PWM time-base output.
// - Unimplemented control and interrupt bits ignore writes and read zero.
// - Fourth and fifth timers are optional; absent bits read zero.
// - Matches pass a postscaler dividing by field plus one, which sets the flag.
// - Counter or control write clears prescaler and postscaler; control write keeps counter.
// - On bit at control bit 2 runs the timer; reset clears counter and scalers.
module ebpt_timer_top
    import ebpt_pkg::*;
#(
    parameter int NUM_TIMERS = 5,
    parameter int ADDR_W     = 8
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [NUM_TIMERS-1:0]      pwm_base_match,
    output logic                       irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Only the full group or the group without the optional pair exists
    if (!(NUM_TIMERS == 3 || NUM_TIMERS == EBPT_MAX_TIMERS)) begin : g_bad_n
        $error("NUM_TIMERS must be 3 or 5");
    end
    if (ADDR_W < 8) begin : g_bad_aw
        $error("ADDR_W must be at least 8");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_TIMERS-1:0][7:0] count;
        logic [NUM_TIMERS-1:0][7:0] period;
        logic [NUM_TIMERS-1:0][7:0] control;
        logic [NUM_TIMERS-1:0][3:0] pre_cnt;
        logic [NUM_TIMERS-1:0][3:0] post_cnt;
        logic [NUM_TIMERS-1:0]      dis;
        logic [NUM_TIMERS-1:0]      pwm_match;
        logic [7:0]                 flags;
        logic [7:0]                 enables;
        logic [7:0]                 prio;
        logic                       irq;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       aw_got;
        logic                       w_got;
        logic [ADDR_W-1:0]          waddr;
        logic [7:0]                 wdata;
        logic                       wstrb0;
        logic                       arready;
        logic                       rvalid;
        logic [1:0]                 rresp;
        logic [31:0]                rdata;
        logic [ADDR_W-1:0]          raddr;
    } ebpt_state_t;

    ebpt_state_t s_r;
    ebpt_state_t s_nxt;

    // Helper terms, also watched by the assertions
    logic [NUM_TIMERS-1:0] tick;
    logic [NUM_TIMERS-1:0] post_hit;
    logic [NUM_TIMERS-1:0] wr_cnt;
    logic [NUM_TIMERS-1:0] wr_ctl;
    logic [7:0]            fmask;
    logic [7:0]            flag_set;
    logic                  do_wr;
    logic                  wen;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Upper address bits must be zero; misaligned words are unmapped
    function automatic ebpt_kind_t dec_kind(input logic [ADDR_W-1:0] a);
        logic [7:0] off;
        off = a[7:0] - EBPT_ADDR_TBASE;
        dec_kind = EBPT_K_NONE;
        if ((a >> 8) == '0) begin
            case (a[7:0])
                EBPT_ADDR_FLAGS:  dec_kind = EBPT_K_FLAGS;
                EBPT_ADDR_ENABLE: dec_kind = EBPT_K_ENABLE;
                EBPT_ADDR_PRIO:   dec_kind = EBPT_K_PRIO;
                EBPT_ADDR_DIS:    dec_kind = EBPT_K_DIS;
                default: begin
                    if (a[7:0] >= EBPT_ADDR_TBASE && off[7:4] < 4'(EBPT_MAX_TIMERS)) begin
                        case (off[3:0])
                            EBPT_OFS_COUNT:   dec_kind = EBPT_K_COUNT;
                            EBPT_OFS_CONTROL: dec_kind = EBPT_K_CONTROL;
                            EBPT_OFS_PERIOD:  dec_kind = EBPT_K_PERIOD;
                            default:          dec_kind = EBPT_K_NONE;
                        endcase
                    end
                end
            endcase
        end
    endfunction : dec_kind

    function automatic logic [3:0] dec_idx(input logic [ADDR_W-1:0] a);
        logic [7:0] off;
        off = a[7:0] - EBPT_ADDR_TBASE;
        dec_idx = off[7:4];
    endfunction : dec_idx

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        ebpt_kind_t wk;
        ebpt_kind_t rk;
        logic [3:0] wi;
        logic [3:0] ri;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [3:0] lim;
        logic       run;
        wk       = EBPT_K_NONE;
        rk       = EBPT_K_NONE;
        wi       = 4'h0;
        ri       = 4'h0;
        wd       = 8'h00;
        rd       = 8'h00;
        lim      = EBPT_PRE_LIM_1;
        run      = 1'b0;
        s_nxt    = s_r;
        s_nxt.pwm_match = '0;
        tick     = '0;
        post_hit = '0;
        wr_cnt   = '0;
        wr_ctl   = '0;
        flag_set = 8'h00;
        fmask    = 8'h00;

        // Only bits of timers that exist are implemented
        for (int i = 0; i < NUM_TIMERS; i++) begin
            fmask[EBPT_FLAG_POS[i]] = 1'b1;
        end

        // Write channel: address and data taken in either order
        if (s_r.awready && s_axi_awvalid) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.waddr  = s_axi_awaddr;
        end
        if (s_r.wready && s_axi_wvalid) begin
            s_nxt.w_got  = 1'b1;
            s_nxt.wdata  = s_axi_wdata[7:0];
            s_nxt.wstrb0 = s_axi_wstrb[0];
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        do_wr = s_nxt.aw_got && s_nxt.w_got && !s_r.bvalid;
        wk    = dec_kind(s_nxt.waddr);
        wi    = dec_idx(s_nxt.waddr);
        wd    = s_nxt.wdata;
        if (do_wr) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = (wk == EBPT_K_NONE) ? EBPT_RESP_SLVERR : EBPT_RESP_OKAY;
        end
        // Data lives in byte lane 0; other lanes alone change nothing
        wen = do_wr && s_nxt.wstrb0;
        s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

        // Per-timer datapath
        for (int i = 0; i < NUM_TIMERS; i++) begin
            wr_cnt[i] = wen && wk == EBPT_K_COUNT && wi == 4'(i);
            wr_ctl[i] = wen && wk == EBPT_K_CONTROL && wi == 4'(i);
            case (s_r.control[i][EBPT_CTRL_PS_LSB+:2])
                2'b00:   lim = EBPT_PRE_LIM_1;
                2'b01:   lim = EBPT_PRE_LIM_4;
                default: lim = EBPT_PRE_LIM_16;
            endcase
            run = s_r.control[i][EBPT_CTRL_ON] && !s_r.dis[i];
            // Counter and control writes win over counting in the same cycle
            tick[i] = run && s_r.pre_cnt[i] == lim && !wr_cnt[i] && !wr_ctl[i];
            if (wr_cnt[i] || wr_ctl[i]) begin
                s_nxt.pre_cnt[i]  = 4'h0;
                s_nxt.post_cnt[i] = 4'h0;
            end else if (run) begin
                s_nxt.pre_cnt[i] = (s_r.pre_cnt[i] == lim) ? 4'h0 : s_r.pre_cnt[i] + 4'h1;
            end
            if (tick[i]) begin
                if (s_r.count[i] == s_r.period[i]) begin
                    s_nxt.count[i]     = 8'h00;
                    s_nxt.pwm_match[i] = 1'b1;
                    post_hit[i] = s_r.post_cnt[i] == s_r.control[i][EBPT_CTRL_PO_LSB+:4];
                    s_nxt.post_cnt[i] = post_hit[i] ? 4'h0 : s_r.post_cnt[i] + 4'h1;
                    flag_set[EBPT_FLAG_POS[i]] = post_hit[i];
                end else begin
                    s_nxt.count[i] = s_r.count[i] + 8'h01;
                end
            end
            if (wr_cnt[i]) begin
                s_nxt.count[i] = wd;
            end
            if (wr_ctl[i]) begin
                s_nxt.control[i] = wd & EBPT_CTRL_MASK;
            end
            if (wen && wk == EBPT_K_PERIOD && wi == 4'(i)) begin
                s_nxt.period[i] = wd;
            end
            // Disabled module is held in its reset state
            if (s_r.dis[i]) begin
                s_nxt.count[i]    = EBPT_COUNT_RST;
                s_nxt.period[i]   = EBPT_PERIOD_RST;
                s_nxt.control[i]  = EBPT_CONTROL_RST;
                s_nxt.pre_cnt[i]  = 4'h0;
                s_nxt.post_cnt[i] = 4'h0;
            end
        end

        // Interrupt registers; a new event beats a clearing write
        if (wen && wk == EBPT_K_FLAGS) begin
            s_nxt.flags = s_r.flags & wd;
        end
        s_nxt.flags = (s_nxt.flags | flag_set) & fmask;
        if (wen && wk == EBPT_K_ENABLE) begin
            s_nxt.enables = wd & fmask;
        end
        if (wen && wk == EBPT_K_PRIO) begin
            s_nxt.prio = wd & fmask;
        end
        if (wen && wk == EBPT_K_DIS) begin
            s_nxt.dis = wd[NUM_TIMERS-1:0];
        end
        s_nxt.irq = |(s_nxt.flags & s_nxt.enables);

        // Read channel: one read at a time, answered the next cycle
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid  = 1'b0;
            s_nxt.arready = 1'b1;
        end
        if (s_r.arready && s_axi_arvalid) begin
            rk = dec_kind(s_axi_araddr);
            ri = dec_idx(s_axi_araddr);
            case (rk)
                EBPT_K_FLAGS:  rd = s_r.flags;
                EBPT_K_ENABLE: rd = s_r.enables;
                EBPT_K_PRIO:   rd = s_r.prio;
                EBPT_K_DIS:    rd = 8'(s_r.dis);
                default:       rd = 8'h00;
            endcase
            // Absent timers decode but read zero
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (ri == 4'(i)) begin
                    if (rk == EBPT_K_COUNT) begin
                        rd = s_r.count[i];
                    end
                    if (rk == EBPT_K_CONTROL) begin
                        rd = s_r.control[i];
                    end
                    if (rk == EBPT_K_PERIOD) begin
                        rd = s_r.period[i];
                    end
                end
            end
            s_nxt.arready = 1'b0;
            s_nxt.rvalid  = 1'b1;
            s_nxt.raddr   = s_axi_araddr;
            s_nxt.rdata   = {24'h000000, rd};
            s_nxt.rresp   = (rk == EBPT_K_NONE) ? EBPT_RESP_SLVERR : EBPT_RESP_OKAY;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r          <= '0;
            s_r.period   <= {NUM_TIMERS{EBPT_PERIOD_RST}};
            s_r.count    <= {NUM_TIMERS{EBPT_COUNT_RST}};
            s_r.control  <= {NUM_TIMERS{EBPT_CONTROL_RST}};
            s_r.awready  <= 1'b1;
            s_r.wready   <= 1'b1;
            s_r.arready  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign s_axi_awready  = s_r.awready;
    assign s_axi_wready   = s_r.wready;
    assign s_axi_bvalid   = s_r.bvalid;
    assign s_axi_bresp    = s_r.bresp;
    assign s_axi_arready  = s_r.arready;
    assign s_axi_rvalid   = s_r.rvalid;
    assign s_axi_rdata    = s_r.rdata;
    assign s_axi_rresp    = s_r.rresp;
    assign pwm_base_match = s_r.pwm_match;
    assign irq            = s_r.irq;

    // ------------------------------------------------------------
    // Assertions on timer 0, control reads and irq
    // ------------------------------------------------------------
    property p_period_reset;
        @(posedge aclk) $rose(aresetn) |-> s_r.period[0] == EBPT_PERIOD_RST;
    endproperty
    a_period_reset: assert property (p_period_reset) else $error("period not all ones");

    property p_wrap;
        @(posedge aclk) disable iff (!aresetn)
            tick[0] && s_r.count[0] == s_r.period[0] |=> s_r.count[0] == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_count_up;
        @(posedge aclk) disable iff (!aresetn)
            tick[0] && s_r.count[0] != s_r.period[0] && !s_r.dis[0]
            |=> s_r.count[0] == $past(s_r.count[0]) + 8'h01;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step");

    property p_pwm_match;
        @(posedge aclk) disable iff (!aresetn)
            ##1 pwm_base_match[0] == $past(tick[0] && s_r.count[0] == s_r.period[0]);
    endproperty
    a_pwm_match: assert property (p_pwm_match) else $error("match pulse wrong");

    property p_ctrl_read;
        @(posedge aclk) disable iff (!aresetn)
            s_axi_rvalid && dec_kind(s_r.raddr) == EBPT_K_CONTROL |-> s_axi_rdata[31:7] == '0;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("reserved bits nonzero");

    property p_prescale16;
        @(posedge aclk) disable iff (!aresetn)
            tick[0] && s_r.control[0][1] && !wr_cnt[0] && !wr_ctl[0]
            |=> (!tick[0] || !s_r.control[0][1]) [*8];
    endproperty
    a_prescale16: assert property (p_prescale16) else $error("prescale too fast");

    property p_flag_set;
        @(posedge aclk) disable iff (!aresetn)
            post_hit[0] && tick[0] |=> s_r.flags[EBPT_FLAG_POS[0]];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_ctrl_write;
        @(posedge aclk) disable iff (!aresetn)
            wr_ctl[0] && !s_r.dis[0]
            |=> s_r.pre_cnt[0] == 4'h0 && s_r.post_cnt[0] == 4'h0
                && s_r.count[0] == $past(s_r.count[0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");

    property p_off_holds;
        @(posedge aclk) disable iff (!aresetn)
            !s_r.control[0][EBPT_CTRL_ON] && !s_r.dis[0] && !wr_cnt[0] |=> $stable(s_r.count[0]);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("stopped timer moved");

    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
            irq == |(s_r.flags & s_r.enables);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_flag_sticky;
        @(posedge aclk) disable iff (!aresetn)
            s_r.flags[0] && !(do_wr && dec_kind(s_nxt.waddr) == EBPT_K_FLAGS) |=> s_r.flags[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    c_wrap:  cover property (@(posedge aclk) disable iff (!aresetn) pwm_base_match[0]);
    c_irq:   cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
    c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid);
    c_read:  cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid);

endmodule : ebpt_timer_top

//--- sim/ebpt_pwm_sink.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Time-base consumer model
// ------------------------------------------------------------
module ebpt_pwm_sink (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  pwm_base_match,
    output logic      [15:0] pulse_cnt_r,
    output logic      [15:0] last_gap_r,
    output logic             wide_seen_r
);
    logic [15:0] since_r;
    logic        prev_r;

    // Counts periods of timer 0 and measures their length
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_cnt_r <= 16'h0000;
            last_gap_r  <= 16'h0000;
            since_r     <= 16'h0000;
            prev_r      <= 1'b0;
            wide_seen_r <= 1'b0;
        end else begin
            prev_r <= pwm_base_match[0];
            if (pwm_base_match[0]) begin
                pulse_cnt_r <= pulse_cnt_r + 16'h0001;
                last_gap_r  <= since_r;
                since_r     <= 16'h0001;
            end else begin
                since_r <= since_r + 16'h0001;
            end
            // A base pulse wider than one cycle would double-count a period
            if (pwm_base_match[0] && prev_r) begin
                wide_seen_r <= 1'b1;
            end
        end
    end
endmodule : ebpt_pwm_sink

//--- sim/eight_bit_period_timer_test.sv
`timescale 1ns/1ps
module eight_bit_period_timer_test;
    import ebpt_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, rs;
    logic [4:0]  pwm;
    logic [15:0] pulse_cnt, last_gap, n0;
    logic        wide_seen;
    logic [31:0] d;
    int          bad_count = 0, checks = 0;
    logic [15:0] gap_exp [4] = '{16'h0004, 16'h0010, 16'h0040, 16'h0040};

    ebpt_timer_top #(.NUM_TIMERS(5), .ADDR_W(8)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pwm_base_match(pwm), .irq(irq)
    );
    ebpt_pwm_sink sink (
        .aclk(aclk), .aresetn(aresetn), .pwm_base_match(pwm),
        .pulse_cnt_r(pulse_cnt), .last_gap_r(last_gap), .wide_seen_r(wide_seen)
    );

    // ------------------------------------------------------------
    // Clock, compare, verdict
    // ------------------------------------------------------------
    always #25 aclk = ~aclk;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // Watchdog: whole sequence needs well under 5000 cycles
    initial begin
        #(50 * 20000);
        bad_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // Bus tasks: release each channel only at the edge it is taken
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
        end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 100);
        r = bresp;
        bready <= 1'b0;
        if (n >= 100) chk("write timeout", 32'h1, 32'h0);
        // Let an edge pass so a following call never re-drives ready in this step
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 100);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 100) chk("read timeout", 32'h1, 32'h0);
        @(posedge aclk);
    endtask : rd

    // Write then read back one register
    task automatic wrd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
        wr(a, v, rs);
        rd(a, d, rs);
        chk("readback", d, {24'h0, e});
        chk("readback resp", {30'h0, rs}, {30'h0, EBPT_RESP_OKAY});
    endtask : wrd

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        do_reset();
        for (int i = 0; i < 5; i++) begin
            rd(8'h18 + 8'(16 * i), d, rs);
            chk("period reset", d, 32'h000000FF);
            rd(8'h10 + 8'(16 * i), d, rs);
            chk("count reset", d, 32'h00000000);
        end
        wrd(8'h18, 8'hA5, 8'hA5);
        wrd(8'h14, 8'hFB, 8'h7B);
        wrd(8'h04, 8'hFF, 8'h75);
        wrd(8'h00, 8'hFF, 8'h00);
        wr(8'hF0, 8'h55, rs);
        chk("unmapped bresp", {30'h0, rs}, {30'h0, EBPT_RESP_SLVERR});
        rd(8'hF0, d, rs);
        chk("unmapped rdata", d, 32'h0);
        chk("unmapped rresp", {30'h0, rs}, {30'h0, EBPT_RESP_SLVERR});
        // Control write with timer off keeps the count
        wr(8'h10, 8'h02, rs);
        wrd(8'h14, 8'h78, 8'h78);
        rd(8'h10, d, rs);
        chk("count kept", d, 32'h00000002);
        // Every prescale code, period 3
        wr(8'h18, 8'h03, rs);
        wr(8'h10, 8'h00, rs);
        for (int ps = 0; ps < 4; ps++) begin
            wr(8'h14, 8'h04 | 8'(ps), rs);
            repeat (3 * gap_exp[ps] + 8) @(posedge aclk);
            chk("base gap", {16'h0, last_gap}, {16'h0, gap_exp[ps]});
        end
        // Postscale 1:3 sets the flag on the third match
        wr(8'h14, 8'h00, rs);
        wr(8'h10, 8'h00, rs);
        wr(8'h00, 8'h00, rs);
        wr(8'h04, 8'h01, rs);
        n0 = pulse_cnt;
        wr(8'h14, 8'h14, rs);
        n = 0;
        while (irq !== 1'b1 && n < 500) begin
            @(posedge aclk);
            n++;
        end
        chk("irq raised", {31'h0, irq}, 32'h1);
        repeat (2) @(posedge aclk);
        chk("matches per flag", {16'h0, pulse_cnt - n0}, 32'h3);
        wr(8'h14, 8'h00, rs);
        repeat (40) @(posedge aclk);
        chk("irq sticky", {31'h0, irq}, 32'h1);
        rd(8'h00, d, rs);
        chk("flag set", d, 32'h00000001);
        wr(8'h00, 8'h00, rs);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        // Masked flag raises no interrupt until enabled
        wr(8'h04, 8'h00, rs);
        wr(8'h14, 8'h04, rs);
        repeat (20) @(posedge aclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rd(8'h00, d, rs);
        chk("flag masked", d, 32'h00000001);
        wr(8'h04, 8'h01, rs);
        @(posedge aclk);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        // Last timer with period 0 matches on every tick; timers 1 to 3 stay quiet
        wr(8'h58, 8'h00, rs);
        wr(8'h54, 8'h04, rs);
        @(posedge aclk);
        chk("other bases", {28'h0, pwm[4:1]}, 32'h00000008);
        // Second reset while running
        do_reset();
        chk("irq after reset", {31'h0, irq}, 32'h0);
        rd(8'h18, d, rs);
        chk("period rereset", d, 32'h000000FF);
        rd(8'h10, d, rs);
        chk("count rereset", d, 32'h00000000);
        chk("single cycle base", {31'h0, wide_seen}, 32'h0);
        close_out();
    end
endmodule : eight_bit_period_timer_test
